// File: design/bfh_pkg.sv
// package of the buffer host: widths, timing counts, state codes
// assumes a single 20 mhz clock; all device pins sit outside that clock
package bfh_pkg;
	localparam int DATA_W = 8; // byte-wide ports
	localparam int FIFO_DEPTH = 32; // user write staging depth
	localparam int CLK_PERIOD_NS = 50; // 20 mhz
	localparam int READ_ACCESS_TIME_NS = 50; // data valid after request falls
	localparam int RESET_HOLD_TIME_NS = 200; // least reset hold time
	localparam int REREAD_PULSE_NS = 100; // least low time of the reread pulse
	// least times round up, never below one cycle
	localparam int ACCESS_CYC = ((READ_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1) ? 1 :
		(READ_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RESET_CYC = ((RESET_HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1) ? 1 :
		(RESET_HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int REREAD_CYC = ((REREAD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1) ? 1 :
		(REREAD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int GAP_CYC = 4; // three-flop sync latency plus one
	localparam int CNT_W = 8; // shared cycle counter width
	localparam logic [CNT_W-1:0] ACCESS_LAST = CNT_W'(ACCESS_CYC);
	localparam logic [CNT_W-1:0] RESET_LAST = CNT_W'(RESET_CYC - 1);
	localparam logic [CNT_W-1:0] REREAD_LAST = CNT_W'(REREAD_CYC - 1);
	localparam logic [CNT_W-1:0] GAP_LAST = CNT_W'(GAP_CYC - 1);
	localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
	// synchronised device status vector layout
	localparam int SYNC_W = 8;
	localparam int IX_READY_A = 7;
	localparam int IX_READY_B = 6;
	localparam int IX_EMPTY_N = 5;
	localparam int IX_FULL_N = 4;
	localparam int IX_FLAGS_LO = 0;
	localparam int FLAGS_W = 4;
	typedef enum logic [7:0] {
		ST_RESET = 8'h01,
		ST_IDLE = 8'h02,
		ST_WSETUP = 8'h04,
		ST_WLOW = 8'h08,
		ST_WHOLD = 8'h10,
		ST_RLOW = 8'h20,
		ST_REREAD = 8'h40,
		ST_GAP = 8'h80
	} bfh_state_t;
endpackage

// File: design/bfh_fifo.sv
// staging fifo for bytes on their way to the buffer device
// assumes one clock and a synchronous active-high reset; depth a power of two
`timescale 1ns/1ps
module bfh_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH); // array holds depth words
	// whole state of the fifo
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem; // storage array
		logic [AW-1:0] wp; // write pointer, wraps naturally
		logic [AW-1:0] rp; // read pointer
		logic [AW:0] cnt; // words in the array
		logic [WIDTH-1:0] odata; // registered read data
		logic ovalid; // output register holds a word
		logic iready; // registered space flag
	} bfh_fifo_st_t;
	bfh_fifo_st_t q;
	bfh_fifo_st_t d;
	logic push;
	logic load;

	// next state: push, refill of the output register, honest counts
	always_comb
	begin
		d = q;
		push = in_valid && q.iready;
		load = (q.cnt != '0) && (!q.ovalid || out_ready);
		if (push)
		begin
			d.mem[q.wp] = in_data;
			d.wp = q.wp + 1'b1;
		end
		// consumer took the word
		if (out_ready && q.ovalid)
			d.ovalid = 1'b0;
		// refill wins over the drain in the same cycle
		if (load)
		begin
			d.odata = q.mem[q.rp];
			d.ovalid = 1'b1;
			d.rp = q.rp + 1'b1;
		end
		d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(load);
		// ready one cycle late after reset; costs nothing, keeps it a flop
		d.iready = (d.cnt != CNT_FULL);
	end

	// registers
	always_ff @(posedge clk)
	begin
		if (srst)
			q <= '0;
		else
			q <= d;
	end

	assign in_ready = q.iready;
	assign out_data = q.odata;
	assign out_valid = q.ovalid;
endmodule

// File: design/bfh_host.sv
// host controller that drives a bidirectional byte buffer device by its pins
// assumes the device pins are asynchronous to CLK; two-way buses split in/out/enable
`timescale 1ns/1ps
// Contract
// - request only while that port ready high
// - reset, requests, reread held high long enough
// - write data stable around request rising edge
// - forced read drains under 64 bytes
// - reread input high except retransmit pulse
// - cascade output looped to cascade input
module bfh_host
	import bfh_pkg::*;
(
	input wire logic CLK,
	input wire logic SRST,
	input wire logic [DATA_W-1:0] WR_DATA,
	input wire logic WR_VALID,
	output logic WR_READY,
	output logic [DATA_W-1:0] RD_DATA,
	output logic RD_VALID,
	input wire logic RD_READY,
	input wire logic DIR_A_WRITES,
	input wire logic FLUSH_REQ,
	input wire logic REREAD_REQ,
	input wire logic [DATA_W-1:0] PORT_A_BUS_I,
	output logic [DATA_W-1:0] PORT_A_BUS_O,
	output logic PORT_A_BUS_OE_N,
	input wire logic [DATA_W-1:0] PORT_B_BUS_I,
	output logic [DATA_W-1:0] PORT_B_BUS_O,
	output logic PORT_B_BUS_OE_N,
	output logic REQ_A_N,
	output logic REQ_B_N,
	input wire logic READY_A,
	input wire logic READY_B,
	output logic DEV_RESET,
	output logic PORT_DIRECTION_SELECT,
	output logic FORCED_READ_REQUEST,
	output logic LEAD_OR_REREAD_INPUT,
	input wire logic DEV_EMPTY_N,
	input wire logic DEV_FULL_N,
	input wire logic [FLAGS_W-1:0] DEV_FLAGS,
	output logic STATUS_EMPTY_N,
	output logic STATUS_FULL_N,
	output logic [FLAGS_W-1:0] STATUS_FLAGS,
	output logic BUSY
);
	// whole state of the controller
	typedef struct packed {
		bfh_state_t st; // sequencer
		logic [CNT_W-1:0] cnt; // cycle counter of the current phase
		logic [CNT_W-1:0] rst_len; // cycles the device reset has been high
		logic [SYNC_W-1:0] s1; // first sync stage
		logic [SYNC_W-1:0] s2; // second sync stage
		logic [SYNC_W-1:0] s3; // third sync stage
		logic [SYNC_W-1:0] filt; // accepted pin levels
		logic dir; // port A is the write port
		logic req_w_n; // write-port request
		logic req_r_n; // read-port request
		logic req_a_n; // mapped pin copies
		logic req_b_n;
		logic [DATA_W-1:0] wbus; // write data driven out
		logic woe_n; // write bus enable, low drives
		logic oe_a_n;
		logic oe_b_n;
		logic dev_rst;
		logic force_rd;
		logic lead;
		logic reread_pend; // retransmit asked, not yet done
		logic last_rd; // fairness between read and write
		logic [DATA_W-1:0] rd_data;
		logic rd_valid;
		logic busy;
	} bfh_host_st_t;

	// reset value: device held in reset, both request pins and the reread pulse pin high
	localparam bfh_host_st_t HOST_RST = '{st: ST_RESET, req_w_n: 1'b1, req_r_n: 1'b1, req_a_n: 1'b1,
		req_b_n: 1'b1, woe_n: 1'b1, oe_a_n: 1'b1, oe_b_n: 1'b1, dev_rst: 1'b1, lead: 1'b1,
		dir: 1'b1, busy: 1'b1, default: '0};

	bfh_host_st_t q;
	bfh_host_st_t d;
	logic [DATA_W-1:0] fifo_data; // next byte for the device
	logic fifo_valid;
	logic fifo_pop;
	logic rdy_w; // accepted ready of the write port
	logic rdy_r; // accepted ready of the read port
	logic can_wr;
	logic can_rd;
	logic [SYNC_W-1:0] agree; // stages two and three match

	// staging fifo; its ready stalls the user when the device holds us off
	bfh_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(CLK),
		.srst(SRST),
		.in_data(WR_DATA),
		.in_valid(WR_VALID),
		.in_ready(WR_READY),
		.out_data(fifo_data),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop)
	);

	// ready per role, picked by the current direction
	assign rdy_w = q.dir ? q.filt[IX_READY_A] : q.filt[IX_READY_B];
	assign rdy_r = q.dir ? q.filt[IX_READY_B] : q.filt[IX_READY_A];

	// next state
	always_comb
	begin
		d = q;
		fifo_pop = 1'b0;
		// three-flop sync; a change counts once stages two and three agree
		d.s1 = {READY_A, READY_B, DEV_EMPTY_N, DEV_FULL_N, DEV_FLAGS};
		d.s2 = q.s1;
		d.s3 = q.s2;
		agree = ~(q.s2 ^ q.s3);
		d.filt = (agree & q.s3) | (~agree & q.filt);
		d.force_rd = FLUSH_REQ;
		can_wr = rdy_w && fifo_valid;
		can_rd = rdy_r && (!q.rd_valid || RD_READY);
		// user drains the read byte
		if (RD_READY)
			d.rd_valid = 1'b0;
		d.cnt = q.cnt + CNT_ONE;
		d.rst_len = q.dev_rst ? (q.rst_len + CNT_ONE) : '0;
		case (q.st)
			ST_RESET:
			begin
				// requests and reread stay high all through the hold
				if (q.cnt == RESET_LAST)
				begin
					d.dev_rst = 1'b0;
					d.st = ST_GAP;
					d.cnt = '0;
				end
			end
			ST_IDLE:
			begin
				d.cnt = '0;
				if (q.reread_pend)
				begin
					// requests are high here, as retransmit needs
					d.lead = 1'b0;
					d.reread_pend = 1'b0;
					d.st = ST_REREAD;
				end
				else if (DIR_A_WRITES != q.dir)
				begin
					// direction moves only with both requests high
					d.dir = DIR_A_WRITES;
					d.st = ST_GAP;
				end
				else if (can_rd && (!can_wr || !q.last_rd))
				begin
					d.req_r_n = 1'b0;
					d.last_rd = 1'b1;
					d.st = ST_RLOW;
				end
				else if (can_wr)
				begin
					// byte leaves the fifo now; exactly one per write cycle
					fifo_pop = 1'b1;
					d.wbus = fifo_data;
					d.woe_n = 1'b0;
					d.last_rd = 1'b0;
					d.st = ST_WSETUP;
				end
			end
			ST_WSETUP:
			begin
				// data already out one cycle ahead of the request
				d.req_w_n = 1'b0;
				d.st = ST_WLOW;
			end
			ST_WLOW:
			begin
				// device takes the byte on this rising edge
				d.req_w_n = 1'b1;
				d.st = ST_WHOLD;
			end
			ST_WHOLD:
			begin
				// bus kept one cycle past the rise for hold time
				d.woe_n = 1'b1;
				d.st = ST_GAP;
				d.cnt = '0;
			end
			ST_RLOW:
			begin
				// sample only after the access time; bus is settled by then
				if (q.cnt == ACCESS_LAST)
				begin
					d.rd_data = q.dir ? PORT_B_BUS_I : PORT_A_BUS_I;
					d.rd_valid = 1'b1;
					d.req_r_n = 1'b1;
					d.st = ST_GAP;
					d.cnt = '0;
				end
			end
			ST_REREAD:
			begin
				if (q.cnt == REREAD_LAST)
				begin
					d.lead = 1'b1;
					d.st = ST_GAP;
					d.cnt = '0;
				end
			end
			ST_GAP:
			begin
				// lets a ready drop reach the synchroniser before the next cycle
				if (q.cnt == GAP_LAST)
					d.st = ST_IDLE;
			end
			default:
			begin
				d.st = ST_IDLE;
			end
		endcase
		// a request arriving as the pending one is taken is kept
		if (REREAD_REQ)
			d.reread_pend = 1'b1;
		// map roles onto pins
		d.req_a_n = d.dir ? d.req_w_n : d.req_r_n;
		d.req_b_n = d.dir ? d.req_r_n : d.req_w_n;
		d.oe_a_n = d.dir ? d.woe_n : 1'b1;
		d.oe_b_n = d.dir ? 1'b1 : d.woe_n;
		d.busy = (d.st != ST_IDLE);
	end

	// registers
	always_ff @(posedge CLK)
	begin
		if (SRST)
			q <= HOST_RST;
		else
			q <= d;
	end

	assign RD_DATA = q.rd_data;
	assign RD_VALID = q.rd_valid;
	assign PORT_A_BUS_O = q.wbus;
	assign PORT_B_BUS_O = q.wbus;
	assign PORT_A_BUS_OE_N = q.oe_a_n;
	assign PORT_B_BUS_OE_N = q.oe_b_n;
	assign REQ_A_N = q.req_a_n;
	assign REQ_B_N = q.req_b_n;
	assign DEV_RESET = q.dev_rst;
	assign PORT_DIRECTION_SELECT = q.dir;
	assign FORCED_READ_REQUEST = q.force_rd;
	assign LEAD_OR_REREAD_INPUT = q.lead;
	assign STATUS_EMPTY_N = q.filt[IX_EMPTY_N];
	assign STATUS_FULL_N = q.filt[IX_FULL_N];
	assign STATUS_FLAGS = q.filt[IX_FLAGS_LO +: FLAGS_W];
	assign BUSY = q.busy;

	// checks on what this controller drives
	property p_dir_stable;
		@(posedge CLK) disable iff (SRST) (!q.req_a_n || !q.req_b_n) |-> $stable(q.dir);
	endproperty
	a_dir_stable: assert property (p_dir_stable)
		else $error("direction changed during a request");
	property p_rd_req_ready;
		@(posedge CLK) disable iff (SRST) $fell(q.req_r_n) |-> $past(rdy_r);
	endproperty
	a_rd_req_ready: assert property (p_rd_req_ready)
		else $error("read request without read ready");
	property p_wr_req_ready;
		@(posedge CLK) disable iff (SRST) $fell(q.req_w_n) |-> $past(rdy_w, 2);
	endproperty
	a_wr_req_ready: assert property (p_wr_req_ready)
		else $error("write request without write ready");
	property p_reset_quiet;
		@(posedge CLK) disable iff (SRST) q.dev_rst |-> (q.req_a_n && q.req_b_n && q.lead);
	endproperty
	a_reset_quiet: assert property (p_reset_quiet)
		else $error("pin low during device reset");
	property p_reset_hold;
		@(posedge CLK) disable iff (SRST) $fell(q.dev_rst) |-> ($past(q.rst_len) >= RESET_LAST);
	endproperty
	a_reset_hold: assert property (p_reset_hold)
		else $error("device reset released too early");
	property p_wdata_stable;
		@(posedge CLK) disable iff (SRST) $rose(q.req_w_n) |-> (!q.woe_n && $stable(q.wbus));
	endproperty
	a_wdata_stable: assert property (p_wdata_stable)
		else $error("write data not held at request rise");
	property p_read_wait;
		@(posedge CLK) disable iff (SRST) $fell(q.req_r_n) |-> ##1 !q.req_r_n ##1 (q.req_r_n && q.rd_valid);
	endproperty
	a_read_wait: assert property (p_read_wait)
		else $error("read request not held through access time");
	property p_reread_quiet;
		@(posedge CLK) disable iff (SRST) !q.lead |-> (q.req_a_n && q.req_b_n && !q.dev_rst);
	endproperty
	a_reread_quiet: assert property (p_reread_quiet)
		else $error("request low during retransmit pulse");
	property p_force_follow;
		@(posedge CLK) disable iff (SRST) ##1 (q.force_rd == $past(FLUSH_REQ));
	endproperty
	a_force_follow: assert property (p_force_follow)
		else $error("forced read pin does not follow flush");
endmodule

// File: tb/bfh_dev_model.sv
// behavioural model of the byte buffer device seen through its pins
// assumes write requests change only while the host drives the bus; bus levels resolved here
`timescale 1ns/1ps
module bfh_dev_model #(
	parameter int CAP = 32768, // storage bytes
	parameter int ACC_NS = 45 // read data delay after request falls
) (
	input wire logic rst,
	input wire logic ps,
	input wire logic forced,
	input wire logic lead,
	input wire logic req_a_n,
	input wire logic req_b_n,
	input wire logic [7:0] a_o,
	input wire logic [7:0] b_o,
	input wire logic a_oe_n,
	input wire logic b_oe_n,
	output logic ready_a,
	output logic ready_b,
	output logic empty_n,
	output logic full_n,
	output logic [3:0] flags,
	output logic [7:0] bus_a,
	output logic [7:0] bus_b
);
	logic [7:0] mem [0:CAP-1]; // one array, so no byte lost between ports
	int wr_cnt = 0; // write address counter
	int rd_cnt = 0; // read address counter
	int level; // stored bytes
	logic w_ok = 1'b0; // write request accepted at its fall
	logic r_ok = 1'b0; // read request accepted at its fall
	logic drv = 1'b0; // read data on the bus
	logic [7:0] rd_q = 8'h5a; // last read byte
	logic rdy_w, rdy_r, reread;
	wire req_w_n = ps ? req_a_n : req_b_n;
	wire req_r_n = ps ? req_b_n : req_a_n;
	wire [7:0] wbus = ps ? bus_a : bus_b;
	// single device: cascade output looped to its input, lead pin high
	always_comb level = wr_cnt - rd_cnt;
	assign reread = ~lead & ~rst;
	assign rdy_w = ~rst & ~reread & ~(forced && level != 0) & (level <= CAP - 64);
	assign rdy_r = ~rst & ~reread & (level >= 64 || (forced && level > 0));
	assign ready_a = ps ? rdy_w : rdy_r;
	assign ready_b = ps ? rdy_r : rdy_w;
	assign empty_n = level != 0;
	assign full_n = level < CAP - 63;
	assign flags = ~4'(level / 2048); // level in 2048-byte steps, active low, inside the allowed error
	// undriven bus shows the inverse of the last byte, never a kind value
	assign bus_a = !a_oe_n ? a_o : (!ps && drv) ? rd_q : ~rd_q;
	assign bus_b = !b_oe_n ? b_o : (ps && drv) ? rd_q : ~rd_q;
	// reset clears both counters, retransmit only the read one
	always @(posedge rst, negedge lead)
	begin
		rd_cnt = 0;
		if (rst)
			wr_cnt = 0;
	end
	// requests met with ready low are ignored
	always @(negedge req_w_n) w_ok = rdy_w;
	always @(posedge req_w_n)
	begin
		if (w_ok && !rst)
		begin
			mem[wr_cnt % CAP] = wbus;
			wr_cnt++;
		end
		w_ok = 1'b0;
	end
	// read data after the access delay, released when the request rises
	always @(negedge req_r_n)
	begin
		if (rdy_r)
		begin
			r_ok = 1'b1;
			#ACC_NS rd_q = mem[rd_cnt % CAP];
			drv = 1'b1;
		end
	end
	always @(posedge req_r_n)
	begin
		if (r_ok && !rst)
			rd_cnt++;
		r_ok = 1'b0;
		drv = 1'b0;
	end
endmodule

// File: tb/bfh_host_tb_top.sv
// self-checking bench for the buffer host against the device model
// assumes a small model capacity so that the full case stays short
`timescale 1ns/1ps
module bfh_host_tb_top;
	import bfh_pkg::*;
	logic clk = 1'b0, srst = 1'b1, wr_valid = 1'b0, rd_ready = 1'b0, dir = 1'b1;
	logic flush_req = 1'b0, reread_req = 1'b0, rd_en = 1'b1, ok;
	logic [7:0] wr_data = 8'h00, rd_data, a_o, b_o, a_i, b_i;
	logic wr_ready, rd_valid, a_oe_n, b_oe_n, req_a_n, req_b_n, rdy_a, rdy_b, dev_reset, ps, frc, lead;
	logic e_n, f_n, st_e_n, st_f_n, busy;
	logic [3:0] flg, st_flg;
	int error_cnt = 0, samples_checked = 0, seed = 32'h375d1290, n;
	logic [7:0] exp_q[$], copy_q[$]; // bytes owed to the reader, bytes written
	always #25 clk = ~clk;
	bfh_host uut (.CLK(clk), .SRST(srst), .WR_DATA(wr_data), .WR_VALID(wr_valid), .WR_READY(wr_ready),
		.RD_DATA(rd_data), .RD_VALID(rd_valid), .RD_READY(rd_ready), .DIR_A_WRITES(dir), .FLUSH_REQ(flush_req),
		.REREAD_REQ(reread_req), .PORT_A_BUS_I(a_i), .PORT_A_BUS_O(a_o), .PORT_A_BUS_OE_N(a_oe_n),
		.PORT_B_BUS_I(b_i), .PORT_B_BUS_O(b_o), .PORT_B_BUS_OE_N(b_oe_n), .REQ_A_N(req_a_n), .REQ_B_N(req_b_n),
		.READY_A(rdy_a), .READY_B(rdy_b), .DEV_RESET(dev_reset), .PORT_DIRECTION_SELECT(ps),
		.FORCED_READ_REQUEST(frc), .LEAD_OR_REREAD_INPUT(lead), .DEV_EMPTY_N(e_n), .DEV_FULL_N(f_n),
		.DEV_FLAGS(flg), .STATUS_EMPTY_N(st_e_n), .STATUS_FULL_N(st_f_n), .STATUS_FLAGS(st_flg), .BUSY(busy));
	// small capacity: full reached after a couple of hundred bytes
	// slowest legal access time; the host samples a full cycle after the data turns valid
	bfh_dev_model #(.CAP(256), .ACC_NS(READ_ACCESS_TIME_NS)) dev (.rst(dev_reset), .ps(ps), .forced(frc), .lead(lead),
		.req_a_n(req_a_n), .req_b_n(req_b_n), .a_o(a_o), .b_o(b_o), .a_oe_n(a_oe_n), .b_oe_n(b_oe_n),
		.ready_a(rdy_a), .ready_b(rdy_b), .empty_n(e_n), .full_n(f_n), .flags(flg), .bus_a(a_i), .bus_b(b_i));
	task complete_run;
		if (error_cnt == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// flag pins show the level in 2K-byte steps, active low
	function automatic logic [7:0] exp_flags(input int lvl);
		return {4'h0, ~4'(lvl / 2048)};
	endfunction
	task check(input string nm, input logic [7:0] e, input logic [7:0] s);
		samples_checked++;
		if (s !== e)
		begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	// wait k edges, then step off the edge
	task tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task do_reset;
		srst = 1'b1;
		wr_valid = 1'b0;
		tick(6);
		check("dev_reset", 8'h01, {7'h0, dev_reset});
		srst = 1'b0;
		exp_q.delete();
		copy_q.delete();
		for (int i = 0; i < 200 && busy !== 1'b0; i++)
			tick(1);
		check("busy", 8'h00, {7'h0, busy});
	endtask
	// offer one byte, holding valid until taken or given up
	task push(input logic [7:0] b, output logic taken);
		int w;
		wr_data = b;
		wr_valid = 1'b1;
		w = 0;
		// ready is a flop: read it settled, then the next edge takes the byte
		while (wr_ready !== 1'b1 && w < 300)
		begin
			tick(1);
			w++;
		end
		taken = (wr_ready === 1'b1);
		tick(1);
		if (taken)
		begin
			exp_q.push_back(b);
			copy_q.push_back(b);
		end
	endtask
	task fill(input int k);
		for (int i = 0; i < k; i++)
			push(8'($random(seed)), ok);
		wr_valid = 1'b0;
	endtask
	// bounded wait until at most k bytes are still owed
	task wait_q(input int k);
		for (int i = 0; i < 4000 && exp_q.size() > k; i++)
			tick(1);
		tick(60);
	endtask
	// forced read empties what standard reads leave behind
	task drain;
		flush_req = 1'b1;
		wait_q(0);
		check("forced_pin", 8'h01, {7'h0, frc});
		flush_req = 1'b0;
		check("left", 8'h00, 8'(exp_q.size()));
		tick(20);
		check("empty_n", 8'h00, {7'h0, st_e_n});
	endtask
	// reader ready changes just after the rising edge
	always @(posedge clk)
	begin
		#1 rd_ready = rd_en & 1'($random(seed));
	end
	// handshake judged at the falling edge, where both sides are settled
	always @(negedge clk)
	begin
		if (rd_valid === 1'b1 && rd_ready === 1'b1 && srst === 1'b0)
		begin
			if (exp_q.size() == 0)
				check("rd_extra", 8'h00, 8'hff);
			else
				check("rd_data", exp_q.pop_front(), rd_data);
		end
	end
	initial
	begin
		do_reset();
		check("lead", 8'h01, {7'h0, lead});
		check("empty_n", 8'h00, {7'h0, st_e_n});
		// both directions: reads stop at 63 bytes, forced read takes the rest
		for (int d = 1; d >= 0; d--)
		begin
			dir = d[0];
			tick(20);
			check("ps", 8'(d), {7'h0, ps});
			fill(80);
			wait_q(63);
			check("level", 8'd63, 8'(dev.level));
			check("empty_n", 8'h01, {7'h0, st_e_n});
			check("flags", exp_flags(63), {4'h0, st_flg});
			drain();
		end
		// retransmit starts the reader again at the first byte
		do_reset();
		fill(80);
		wait_q(63);
		exp_q = copy_q;
		reread_req = 1'b1;
		tick(1);
		reread_req = 1'b0;
		tick(10);
		drain();
		// no reader: writes stop once the device reports full
		do_reset();
		rd_en = 1'b0;
		n = 0;
		do
		begin
			push(8'($random(seed)), ok);
			n++;
		end
		while (ok && n < 400);
		wr_valid = 1'b0;
		tick(40);
		check("full_n", 8'h00, {7'h0, st_f_n});
		check("level", 8'd193, 8'(dev.level));
		// reader back: write ready returns once reads leave the top range
		rd_en = 1'b1;
		wait_q(63);
		check("full_n", 8'h01, {7'h0, st_f_n});
		check("owed", 8'd63, 8'(exp_q.size()));
		do_reset();
		check("level", 8'h00, 8'(dev.level));
		complete_run();
	end
	// hang guard: about four times the expected run length
	initial
	begin
		repeat (30000) @(posedge clk);
		error_cnt++;
		complete_run();
	end
endmodule
